// *** rtl/dcst_pkg.sv ***
// Purpose: Shared constants for the DMA CRC seed and feedback-tap unit.
// Assumes: One 32-bit register word per aligned byte address on a plain port.
// Notes: Every offset, field position and register reset value used by the logic lives here.
//
// Functional notes
// - Value register write seeds the CRC generator.
// - Value read returns current CRC, undisturbed.
// - Value bits above polynomial length read zero; the code masks them in LFSR mode only.
// - Control bit 15: one checksum, zero LFSR.
// - Checksum mode: upper sixteen value bits zero.
// - Checksum mode: written value reads complemented.
// - Checksum mode ignores the feedback-tap register.
// - Set tap bit enables XOR at stage.
// - Clear tap bit: stage copies previous stage.
package dcst_pkg;

    // ------------------------------------------------------------------
    // Widths
    // ------------------------------------------------------------------
    // Data width of the register port and of the shift register.
    localparam int unsigned DCST_DATA_W = 32;
    // Width of the register address.
    localparam int unsigned DCST_ADDR_W = 8;
    // Width of the polynomial length field (length minus one).
    localparam int unsigned DCST_POLYNOMIAL_LENGTH_W = 5;
    // Width of one byte fed in by the DMA engine.
    localparam int unsigned DCST_BYTE_W = 8;
    // Width of the ones-complement checksum.
    localparam int unsigned DCST_CSUM_W = 16;

    // ------------------------------------------------------------------
    // Register byte addresses
    // ------------------------------------------------------------------
    localparam logic [7:0] DCST_ADDR_CONTROL = 8'h00;
    localparam logic [7:0] DCST_ADDR_RUNNING_VALUE = 8'h04;
    localparam logic [7:0] DCST_ADDR_FEEDBACK_TAP_MASK = 8'h08;

    // ------------------------------------------------------------------
    // Control register fields
    // ------------------------------------------------------------------
    // Position of the type select bit.
    localparam int unsigned DCST_TYPE_BIT = 15;
    // Lowest bit of the polynomial length field.
    localparam int unsigned DCST_POLYNOMIAL_LENGTH_LSB = 8;
    // Value of the type select bit that chooses the checksum mode.
    localparam logic DCST_TYPE_IP = 1'b1;

    // ------------------------------------------------------------------
    // Reset values
    // ------------------------------------------------------------------
    localparam logic [31:0] DCST_RUNNING_VALUE_RST = 32'h0000_0000;
    localparam logic [31:0] DCST_TAP_MASK_RST = 32'h0000_0000;
    localparam logic [4:0] DCST_POLYNOMIAL_LENGTH_RST = 5'h1F;
    localparam logic DCST_TYPE_RST = 1'b0;
    localparam logic [31:0] DCST_ZERO_WORD = 32'h0000_0000;
    localparam logic [31:0] DCST_ALL_ONES = 32'hFFFF_FFFF;
    localparam logic [4:0] DCST_TOP_INDEX = 5'h1F;

endpackage

// *** rtl/dcst_lfsr_byte.sv ***
// Purpose: Advance a programmable Galois shift register by one byte.
// Assumes: Byte enters most significant bit first; taps and mask are stable.
// Notes: Purely combinational; the caller registers the result.
`timescale 1ns/10ps

module dcst_lfsr_byte
    import dcst_pkg::*;
#(
    parameter int unsigned WIDTH = DCST_DATA_W,
    parameter int unsigned BYTE_W = DCST_BYTE_W
) (
    input wire logic [WIDTH-1:0] curState,
    input wire logic [WIDTH-1:0] tapMask,
    input wire logic [WIDTH-1:0] lenMask,
    input wire logic [$clog2(WIDTH)-1:0] topIndex,
    input wire logic [BYTE_W-1:0] dataByte,
    output logic [WIDTH-1:0] nextState
);

    // ------------------------------------------------------------------
    // Bit-serial chain
    // ------------------------------------------------------------------
    // One link per data bit; link zero is the current state.
    logic [WIDTH-1:0] chain [BYTE_W+1];
    // Feedback bit of each link.
    logic [BYTE_W-1:0] feedBit;

    assign chain[0] = curState;

    // Each link shifts one stage up and folds feedback into tapped stages.
    for (genvar k = 0; k < BYTE_W; k++) begin : g_step
        assign feedBit[k] = chain[k][topIndex] ^ dataByte[BYTE_W-1-k];
        assign chain[k+1] = ((chain[k] << 1) ^ (tapMask & {WIDTH{feedBit[k]}})) & lenMask;
    end

    assign nextState = chain[BYTE_W];

endmodule

// *** rtl/dcst_crc_unit.sv ***
// Purpose: CRC unit beside a DMA engine, with seed and feedback-tap registers.
// Assumes: Register port and byte feed are on core_clk; no clock crossing needed.
// Notes: Two modes, a programmable LFSR and a ones-complement IP header sum.
`timescale 1ns/10ps

module dcst_crc_unit
    import dcst_pkg::*;
#(
    parameter int unsigned DATA_W = DCST_DATA_W,
    parameter int unsigned ADDR_W = DCST_ADDR_W
) (
    input wire logic core_clk,
    input wire logic rst,
    input wire logic [ADDR_W-1:0] regAddr,
    input wire logic [DATA_W-1:0] regWdata,
    input wire logic regWrite,
    input wire logic regRead,
    output logic [DATA_W-1:0] regRdata,
    input wire logic feedValid,
    input wire logic [DCST_BYTE_W-1:0] feedByte,
    output logic [DATA_W-1:0] crcValue,
    output logic crcModeIp
);

    // ------------------------------------------------------------------
    // State
    // ------------------------------------------------------------------
    // All flip-flops of the block, registered together.
    typedef struct packed {
        logic typeSel;                      // Mode select, one for checksum.
        logic [DCST_POLYNOMIAL_LENGTH_W-1:0] polyLen;    // Length minus one.
        logic [DATA_W-1:0] runVal;          // Running CRC or checksum.
        logic [DATA_W-1:0] taps;            // Feedback-tap mask.
        logic [DCST_BYTE_W-1:0] ipHiByte;   // Held first byte of a word.
        logic ipHalf;                       // A first byte is held.
        logic [DATA_W-1:0] rdata;           // Read data, one cycle late.
    } dcst_state_s;

    dcst_state_s s_reg;
    dcst_state_s s_next;

    // ------------------------------------------------------------------
    // Decode
    // ------------------------------------------------------------------
    // Write and read selects for each register.
    logic wrCtrl;
    logic wrValue;
    logic wrTaps;
    logic rdCtrl;
    logic rdValue;
    logic rdTaps;

    assign wrCtrl = regWrite && (regAddr == DCST_ADDR_CONTROL);
    assign wrValue = regWrite && (regAddr == DCST_ADDR_RUNNING_VALUE);
    assign wrTaps = regWrite && (regAddr == DCST_ADDR_FEEDBACK_TAP_MASK);
    assign rdCtrl = regRead && (regAddr == DCST_ADDR_CONTROL);
    assign rdValue = regRead && (regAddr == DCST_ADDR_RUNNING_VALUE);
    assign rdTaps = regRead && (regAddr == DCST_ADDR_FEEDBACK_TAP_MASK);

    // ------------------------------------------------------------------
    // Length mask
    // ------------------------------------------------------------------
    // Mask of the active low-order stages; a length field of all ones is 32.
    logic [DATA_W-1:0] lenMask;
    // Shift distance that trims the all-ones word down to the length.
    logic [DCST_POLYNOMIAL_LENGTH_W-1:0] trimShift;
    // True when the checksum mode is selected.
    logic modeIp;

    assign modeIp = (s_reg.typeSel == DCST_TYPE_IP);
    assign trimShift = DCST_TOP_INDEX - s_reg.polyLen;
    assign lenMask = DCST_ALL_ONES >> trimShift;

    // ------------------------------------------------------------------
    // LFSR step
    // ------------------------------------------------------------------
    // Next LFSR value after one fed byte.
    logic [DATA_W-1:0] lfsrNext;

    dcst_lfsr_byte #(
        .WIDTH(DATA_W),
        .BYTE_W(DCST_BYTE_W)
    ) u_step (
        .curState(s_reg.runVal),
        .tapMask(s_reg.taps),
        .lenMask(lenMask),
        .topIndex(s_reg.polyLen),
        .dataByte(feedByte),
        .nextState(lfsrNext)
    );

    // ------------------------------------------------------------------
    // Checksum step
    // ------------------------------------------------------------------
    // Sum of the held word and the running value, with the carry folded back.
    logic [DCST_CSUM_W:0] sumWide;
    logic [DCST_CSUM_W-1:0] sumFold;

    assign sumWide = {1'b0, s_reg.runVal[DCST_CSUM_W-1:0]} + {1'b0, s_reg.ipHiByte, feedByte};
    // End-around carry; the fold cannot overflow a second time.
    assign sumFold = sumWide[DCST_CSUM_W-1:0] + {{(DCST_CSUM_W-1){1'b0}}, sumWide[DCST_CSUM_W]};

    // ------------------------------------------------------------------
    // Readable views
    // ------------------------------------------------------------------
    // What a read of the value register shows in the current cycle.
    logic [DATA_W-1:0] valueView;
    // What a read of the control register shows.
    logic [DATA_W-1:0] ctrlView;

    // Value view depends on the mode; the stored value itself is untouched.
    always_comb begin
        if (modeIp) begin
            valueView = {{(DATA_W-DCST_CSUM_W){1'b0}}, ~s_reg.runVal[DCST_CSUM_W-1:0]};
        end else begin
            valueView = s_reg.runVal & lenMask;
        end
    end

    // Control view places the mode bit and the length field, the rest zero.
    always_comb begin
        ctrlView = DCST_ZERO_WORD;
        ctrlView[DCST_TYPE_BIT] = s_reg.typeSel;
        ctrlView[DCST_POLYNOMIAL_LENGTH_LSB +: DCST_POLYNOMIAL_LENGTH_W] = s_reg.polyLen;
    end

    // ------------------------------------------------------------------
    // Next state
    // ------------------------------------------------------------------
    // A seed write wins over a byte fed in the same cycle, so software
    // always knows exactly where the computation restarts.
    always_comb begin
        s_next = s_reg;

        if (wrCtrl) begin
            s_next.typeSel = regWdata[DCST_TYPE_BIT];
            s_next.polyLen = regWdata[DCST_POLYNOMIAL_LENGTH_LSB +: DCST_POLYNOMIAL_LENGTH_W];
            // A mode change drops any half-collected checksum word.
            s_next.ipHalf = 1'b0;
        end

        // Taps are only latched here; a byte in the same cycle uses the old mask.
        if (wrTaps) begin
            s_next.taps = regWdata;
        end

        if (wrValue) begin
            if (modeIp) begin
                s_next.runVal = {{(DATA_W-DCST_CSUM_W){1'b0}}, regWdata[DCST_CSUM_W-1:0]};
            end else begin
                s_next.runVal = regWdata;
            end
            s_next.ipHalf = 1'b0;
        end else if (feedValid) begin
            if (modeIp) begin
                if (s_reg.ipHalf) begin
                    s_next.runVal = {{(DATA_W-DCST_CSUM_W){1'b0}}, sumFold};
                    s_next.ipHalf = 1'b0;
                end else begin
                    s_next.ipHiByte = feedByte;
                    s_next.ipHalf = 1'b1;
                end
            end else begin
                s_next.runVal = lfsrNext;
            end
        end

        if (rdValue) begin
            s_next.rdata = valueView;
        end else if (rdCtrl) begin
            s_next.rdata = ctrlView;
        end else if (rdTaps) begin
            s_next.rdata = s_reg.taps;
        end else begin
            // Unmapped reads and idle cycles return zero.
            s_next.rdata = DCST_ZERO_WORD;
        end
    end

    // ------------------------------------------------------------------
    // Registers
    // ------------------------------------------------------------------
    // Synchronous reset to the documented register reset values.
    always_ff @(posedge core_clk) begin
        if (rst) begin
            s_reg.typeSel <= DCST_TYPE_RST;
            s_reg.polyLen <= DCST_POLYNOMIAL_LENGTH_RST;
            s_reg.runVal <= DCST_RUNNING_VALUE_RST;
            s_reg.taps <= DCST_TAP_MASK_RST;
            s_reg.ipHiByte <= '0;
            s_reg.ipHalf <= 1'b0;
            s_reg.rdata <= DCST_ZERO_WORD;
        end else begin
            s_reg <= s_next;
        end
    end

    // ------------------------------------------------------------------
    // Outputs
    // ------------------------------------------------------------------
    assign regRdata = s_reg.rdata;
    assign crcValue = s_reg.runVal;
    assign crcModeIp = s_reg.typeSel;

    // ------------------------------------------------------------------
    // Assertions
    // ------------------------------------------------------------------
    // In LFSR mode a seed write lands in the running value on the next edge.
    property p_seed_load;
        @(posedge core_clk) disable iff (rst)
        (wrValue && !modeIp) |=> (s_reg.runVal == $past(regWdata));
    endproperty
    a_seed_load: assert property (p_seed_load)
        else $error("Seed write did not load the running value.");

    // A read returns the view of the cycle it was issued in.
    property p_read_current;
        @(posedge core_clk) disable iff (rst)
        rdValue |=> (regRdata == $past(valueView));
    endproperty
    a_read_current: assert property (p_read_current)
        else $error("Value read did not return the current result.");

    // A read alone leaves the running value where it was.
    property p_read_no_disturb;
        @(posedge core_clk) disable iff (rst)
        (rdValue && !feedValid && !regWrite) |=> $stable(s_reg.runVal);
    endproperty
    a_read_no_disturb: assert property (p_read_no_disturb)
        else $error("Value read disturbed the computation.");

    // Bits above the length read as zero in LFSR mode.
    property p_upper_zero_lfsr;
        @(posedge core_clk) disable iff (rst)
        (rdValue && !modeIp) |=> ((regRdata & ~$past(lenMask)) == DCST_ZERO_WORD);
    endproperty
    a_upper_zero_lfsr: assert property (p_upper_zero_lfsr)
        else $error("Value bits above the length were not zero.");

    // The mode bit follows bit 15 of a control write.
    property p_mode_select;
        @(posedge core_clk) disable iff (rst)
        wrCtrl |=> (crcModeIp == $past(regWdata[DCST_TYPE_BIT]));
    endproperty
    a_mode_select: assert property (p_mode_select)
        else $error("Mode select did not follow the control write.");

    // The upper half reads as zero in checksum mode.
    property p_upper_zero_ip;
        @(posedge core_clk) disable iff (rst)
        (rdValue && modeIp) |=> (regRdata[DATA_W-1:DCST_CSUM_W] == '0);
    endproperty
    a_upper_zero_ip: assert property (p_upper_zero_ip)
        else $error("Upper checksum half was not zero.");

    // A written checksum shows complemented in the read view in the next cycle.
    property p_ip_complement;
        @(posedge core_clk) disable iff (rst)
        (wrValue && modeIp) |=>
            (valueView == {{(DATA_W-DCST_CSUM_W){1'b0}}, ~$past(regWdata[DCST_CSUM_W-1:0])});
    endproperty
    a_ip_complement: assert property (p_ip_complement)
        else $error("Checksum did not read back complemented.");

    // In checksum mode a fed byte never shifts through the tap network.
    property p_ip_ignores_taps;
        @(posedge core_clk) disable iff (rst)
        (feedValid && modeIp && !wrValue && !s_reg.ipHalf) |=> $stable(s_reg.runVal);
    endproperty
    a_ip_ignores_taps: assert property (p_ip_ignores_taps)
        else $error("Checksum mode changed the value on a first byte.");

    // From zero, a lone low bit leaves exactly the tap pattern.
    property p_tap_enable;
        @(posedge core_clk) disable iff (rst)
        (feedValid && !modeIp && !wrValue && (s_reg.runVal == DCST_ZERO_WORD)
            && (feedByte == 8'h01)) |=> (s_reg.runVal == ($past(s_reg.taps) & $past(lenMask)));
    endproperty
    a_tap_enable: assert property (p_tap_enable)
        else $error("Set tap bits did not take the feedback.");

    // With no taps and zero data the register only shifts.
    property p_tap_clear_shift;
        @(posedge core_clk) disable iff (rst)
        (feedValid && !modeIp && !wrValue && (s_reg.taps == DCST_ZERO_WORD)
            && (feedByte == 8'h00)) |=>
            (s_reg.runVal == (($past(s_reg.runVal) << 8) & $past(lenMask)));
    endproperty
    a_tap_clear_shift: assert property (p_tap_clear_shift)
        else $error("Untapped stages did not copy the previous stage.");

    // After a byte in LFSR mode the value holds nothing above the active length.
    property p_length_bound;
        @(posedge core_clk) disable iff (rst)
        (feedValid && !modeIp && !regWrite) |=> ((s_reg.runVal & ~lenMask) == DCST_ZERO_WORD);
    endproperty
    a_length_bound: assert property (p_length_bound)
        else $error("Running value grew past the active length.");

    // Outside the cycle after a read the data lines rest at zero.
    property p_rdata_idle_zero;
        @(posedge core_clk) disable iff (rst)
        !regRead |=> (regRdata == DCST_ZERO_WORD);
    endproperty
    a_rdata_idle_zero: assert property (p_rdata_idle_zero)
        else $error("Read data did not return to zero after the read.");

    // A control read shows the mode bit that is in force.
    property p_ctrl_mode_view;
        @(posedge core_clk) disable iff (rst)
        rdCtrl |=> (regRdata[DCST_TYPE_BIT] == $past(crcModeIp));
    endproperty
    a_ctrl_mode_view: assert property (p_ctrl_mode_view)
        else $error("Control read did not show the mode bit.");

    // A tap write lands whole in the feedback-tap mask.
    property p_tap_load;
        @(posedge core_clk) disable iff (rst)
        wrTaps |=> (s_reg.taps == $past(regWdata));
    endproperty
    a_tap_load: assert property (p_tap_load)
        else $error("Tap write did not land in the mask.");

    // A checksum seed keeps only the low half of the written word.
    property p_ip_seed_low;
        @(posedge core_clk) disable iff (rst)
        (wrValue && modeIp) |=>
            (crcValue == {{(DATA_W-DCST_CSUM_W){1'b0}}, $past(regWdata[DCST_CSUM_W-1:0])});
    endproperty
    a_ip_seed_low: assert property (p_ip_seed_low)
        else $error("Checksum seed did not keep only the low half.");

    // A control write sets how many stages are active.
    property p_length_load;
        @(posedge core_clk) disable iff (rst)
        wrCtrl |=> (s_reg.polyLen == $past(regWdata[DCST_POLYNOMIAL_LENGTH_LSB +: DCST_POLYNOMIAL_LENGTH_W]));
    endproperty
    a_length_load: assert property (p_length_load)
        else $error("Control write did not set the active length.");

endmodule

// *** verification/dcst_crc_unit_tb.sv ***
// Purpose: Self-checking bench for the DMA CRC seed and feedback-tap unit.
// Assumes: Register port and byte feed share core_clk; inputs change by NBA at the rising edge.
// Notes: Expected values come from a bench model of the shift register and ones-complement sum.
`timescale 1ns/10ps

module dcst_crc_unit_tb;
    import dcst_pkg::*;

    // ------------------------------------------------------------------
    // Signals
    // ------------------------------------------------------------------
    logic core_clk = 1'b0; // Clock at 125 MHz.
    logic rst = 1'b1; // Synchronous reset, held for 8 cycles.
    logic [7:0] regAddr = 8'h00; // Register byte address.
    logic [31:0] regWdata = 32'h0000_0000; // Register write data.
    logic regWrite = 1'b0; // Write strobe.
    logic regRead = 1'b0; // Read strobe.
    logic [31:0] regRdata; // Read data, one cycle after the read strobe.
    logic feedValid = 1'b0; // Byte strobe from the DMA side.
    logic [7:0] feedByte = 8'h00; // Byte from the DMA side.
    logic [31:0] crcValue; // Raw stored running value.
    logic crcModeIp; // Mode bit as seen by the logic.
    int nFail = 0; // Mismatches seen.
    int nCompared = 0; // Comparisons made.
    int cycles = 0; // Cycle count for the hang guard.

    // Half period of 4 ns gives the 8 ns clock.
    always #4 core_clk = ~core_clk;

    dcst_crc_unit u_dcst_crc_unit (
        .core_clk(core_clk),
        .rst(rst),
        .regAddr(regAddr),
        .regWdata(regWdata),
        .regWrite(regWrite),
        .regRead(regRead),
        .regRdata(regRdata),
        .feedValid(feedValid),
        .feedByte(feedByte),
        .crcValue(crcValue),
        .crcModeIp(crcModeIp)
    );

    // ------------------------------------------------------------------
    // Reporting
    // ------------------------------------------------------------------
    // The whole run needs well under a thousand cycles, so 5000 means a hang.
    always @(posedge core_clk) begin
        cycles++;
        if (cycles == 5000) begin
            nFail++;
            endSim();
        end
    end

    // Prints the counts and the verdict, then stops.
    task automatic endSim();
        $display("Compared %0d values, %0d mismatches", nCompared, nFail);
        if (nFail == 0 && nCompared > 0) begin
            $display("Result: passed");
        end else begin
            $display("Result: failed");
        end
        $finish;
    endtask

    // Compares one 32-bit word with case equality so unknowns never match.
    task automatic chk32(logic [31:0] got, logic [31:0] exp);
        nCompared++;
        if (got !== exp) begin
            nFail++;
            $display("Error t=%0t got=%h exp=%h", $time, got, exp);
        end
    endtask

    // Compares one flag.
    task automatic chk1(logic got, logic exp);
        nCompared++;
        if (got !== exp) begin
            nFail++;
            $display("Error t=%0t got=%h exp=%h", $time, got, exp);
        end
    endtask

    // ------------------------------------------------------------------
    // Bus and feed drivers
    // ------------------------------------------------------------------
    // One-cycle write strobe; the register holds the value one cycle later.
    task automatic wr(logic [7:0] addr, logic [31:0] data);
        @(posedge core_clk);
        regWrite <= 1'b1;
        regAddr <= addr;
        regWdata <= data;
        @(posedge core_clk);
        regWrite <= 1'b0;
        #1;
    endtask

    // One-cycle read strobe; the data stand only in the following cycle.
    task automatic rd(logic [7:0] addr, logic [31:0] exp);
        @(posedge core_clk);
        regRead <= 1'b1;
        regAddr <= addr;
        @(posedge core_clk);
        regRead <= 1'b0;
        #1;
        chk32(regRdata, exp);
    endtask

    // Two bytes back to back; crcValue settles one cycle after the last.
    task automatic feed2(logic [7:0] b0, logic [7:0] b1);
        @(posedge core_clk);
        feedValid <= 1'b1;
        feedByte <= b0;
        @(posedge core_clk);
        feedByte <= b1;
        @(posedge core_clk);
        feedValid <= 1'b0;
        #1;
    endtask

    // ------------------------------------------------------------------
    // Reference models
    // ------------------------------------------------------------------
    // Shift register model, MSB first, active stages limited to len.
    function automatic logic [31:0] lfsrByte(logic [31:0] s, logic [31:0] taps, int len,
                                             logic [7:0] b);
        logic [31:0] mask;
        logic fb;
        mask = (len == 32) ? 32'hFFFF_FFFF : ((32'h0000_0001 << len) - 32'h0000_0001);
        for (int i = 7; i >= 0; i--) begin
            fb = s[len-1] ^ b[i];
            s = ((s << 1) ^ (taps & {32{fb}})) & mask;
        end
        return s;
    endfunction

    // Ones-complement add with end-around carry.
    function automatic logic [15:0] onesAdd(logic [15:0] a, logic [15:0] b);
        logic [16:0] s;
        s = {1'b0, a} + {1'b0, b};
        return s[15:0] + {15'h0000, s[16]};
    endfunction

    // ------------------------------------------------------------------
    // Scenarios
    // ------------------------------------------------------------------
    // Reset values, then an unmapped address that must neither store nor answer.
    task automatic scnResetAndUnmapped();
        rd(DCST_ADDR_CONTROL, 32'h0000_1F00);
        rd(DCST_ADDR_RUNNING_VALUE, 32'h0000_0000);
        rd(DCST_ADDR_FEEDBACK_TAP_MASK, 32'h0000_0000);
        chk1(crcModeIp, 1'b0);
        wr(8'h0C, 32'hA5A5_A5A5);
        rd(8'h0C, 32'h0000_0000);
        rd(DCST_ADDR_FEEDBACK_TAP_MASK, 32'h0000_0000);
    endtask

    // One shift-register case: length, taps, seed, two bytes fed back to back.
    task automatic scnLfsr(int len, logic [31:0] taps, logic [31:0] seed,
                           logic [7:0] b0, logic [7:0] b1);
        logic [31:0] mask;
        logic [31:0] exp;
        mask = (len == 32) ? 32'hFFFF_FFFF : ((32'h0000_0001 << len) - 32'h0000_0001);
        wr(DCST_ADDR_CONTROL, 32'(len - 1) << 8);
        rd(DCST_ADDR_CONTROL, 32'(len - 1) << 8);
        chk1(crcModeIp, 1'b0);
        wr(DCST_ADDR_FEEDBACK_TAP_MASK, taps);
        rd(DCST_ADDR_FEEDBACK_TAP_MASK, taps);
        wr(DCST_ADDR_RUNNING_VALUE, seed);
        rd(DCST_ADDR_RUNNING_VALUE, seed & mask);
        exp = lfsrByte(lfsrByte(seed, taps, len, b0), taps, len, b1);
        feed2(b0, b1);
        chk32(crcValue, exp);
        rd(DCST_ADDR_RUNNING_VALUE, exp & mask);
        rd(DCST_ADDR_RUNNING_VALUE, exp & mask);
    endtask

    // Checksum mode with all taps set, a carry-out word, then back to shift mode.
    task automatic scnIpSum();
        logic [15:0] sum;
        wr(DCST_ADDR_FEEDBACK_TAP_MASK, 32'hFFFF_FFFF);
        wr(DCST_ADDR_CONTROL, 32'h0000_9F00);
        chk1(crcModeIp, 1'b1);
        rd(DCST_ADDR_CONTROL, 32'h0000_9F00);
        wr(DCST_ADDR_RUNNING_VALUE, 32'h1234_5678);
        chk32(crcValue, 32'h0000_5678);
        rd(DCST_ADDR_RUNNING_VALUE, 32'h0000_A987);
        sum = onesAdd(16'h5678, 16'h4500);
        feed2(8'h45, 8'h00);
        chk32(crcValue, {16'h0000, sum});
        rd(DCST_ADDR_RUNNING_VALUE, {16'h0000, ~sum});
        sum = onesAdd(sum, 16'hFFFF);
        feed2(8'hFF, 8'hFF);
        chk32(crcValue, {16'h0000, sum});
        rd(DCST_ADDR_RUNNING_VALUE, {16'h0000, ~sum});
        wr(DCST_ADDR_CONTROL, 32'h0000_1F00);
        chk1(crcModeIp, 1'b0);
        rd(DCST_ADDR_RUNNING_VALUE, {16'h0000, sum});
    endtask

    // ------------------------------------------------------------------
    // Main sequence
    // ------------------------------------------------------------------
    initial begin
        repeat (8) @(posedge core_clk);
        rst <= 1'b0;
        scnResetAndUnmapped();
        // Short register with taps, seed bits above the length set.
        scnLfsr(8, 32'h0000_0007, 32'h0000_01A5, 8'h31, 8'h32);
        // No taps: stages only copy their neighbour.
        scnLfsr(8, 32'h0000_0000, 32'h0000_0081, 8'h00, 8'h80);
        // Full length and the single-stage boundary.
        scnLfsr(32, 32'h04C1_1DB7, 32'hFFFF_FFFF, 8'h31, 8'hC3);
        scnLfsr(1, 32'h0000_0001, 32'h0000_0001, 8'h5A, 8'hF0);
        // Zero seed and a lone low bit leave the tap pattern, then a zero byte shifts it on.
        scnLfsr(16, 32'h0000_1021, 32'h0000_0000, 8'h01, 8'h00);
        scnIpSum();
        endSim();
    end

endmodule
